//--- design/ucrd_ctrl.sv
// Card retry, transceiver drive output and DMA-on-error control with Avalon-MM registers
// Notes on behaviour
// [R1] While port is on, retry limit accepts only zero, which stops retransmission.
// [R2] Retry limit zero means no automatic retransmission when transmitting.
// [R3] Limit one to seven sets retransmission attempts before an error is signalled.
// [R4] Without card support the retry limit field reads and stays zero.
// [R5] Polarity bit clear gives active-high drive output, set gives active-low.
// [R6] Transceiver control set puts the drive output on the request-to-send pin.
// [R7] Software changes polarity, transceiver and DMA-halt bits only while port is off.
// [R8] Without driver support, polarity and transceiver bits are reserved and stay clear.
// [R9] Halt off: bad character sets its error flag, no ready, no DMA request.
// [R10] Halt on: bad character sets error and ready; DMA masked until error cleared.
// [R11] Software drops DMA enable or ready before clearing a masked error flag.
// [R12] Limit counts transmit retries before frame error, receive retries before parity error.
`include "ucrd_map.svh"

module ucrd_ctrl #(
    parameter bit CARD_SUPPORT = 1'h1,
    parameter bit DRIVER_SUPPORT = 1'h1
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [`UCRD_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [`UCRD_DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [`UCRD_DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic tx_busy_in,
    input wire logic tx_nack_in,
    input wire logic tx_char_done_in,
    input wire logic rts_flow_in,
    input wire logic rx_char_valid_in,
    input wire logic [8:0] rx_data_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_frame_err_in,
    input wire logic rx_noise_err_in,
    input wire logic dma_rx_ack_in,
    output logic tx_retransmit_out,
    output logic tx_retry_stop_out,
    output logic rx_nack_out,
    output logic rts_pin_out,
    output logic dma_rx_req_out,
    output logic irq_out
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] ucrd_lane_mask(input logic [3:0] be);
        ucrd_lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] ucrd_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] be);
        ucrd_merge = (old_word & ~ucrd_lane_mask(be)) | (new_word & ucrd_lane_mask(be));
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ack_q;
    logic bus_req;
    logic wr_take;
    logic rd_take;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic rd_data;
    logic [31:0] rd_word;
    logic [31:0] readdata_q;

    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~ack_q;
    assign wr_take = avs_write_in & ack_q;
    assign rd_take = avs_read_in & ack_q;
    assign wr_ctrl = wr_take & (avs_address_in == `UCRD_OFF_CTRL);
    assign wr_status = wr_take & (avs_address_in == `UCRD_OFF_STATUS);
    assign wr_mask = wr_take & (avs_address_in == `UCRD_OFF_MASK);
    assign rd_data = rd_take & (avs_address_in == `UCRD_OFF_DATA);
    assign avs_readdata_out = readdata_q;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_q <= 1'h0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic port_switched_on_q;
    logic dma_receive_request_on_q;
    logic card_mode_q;
    logic dma_halt_on_rx_error_q;
    logic transceiver_control_on_q;
    logic drive_output_polarity_q;
    logic [2:0] card_retry_limit_q;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [2:0] limit_new;
    logic retry_zero_wr;

    always_comb begin
        ctrl_word = `UCRD_WORD_RESET;
        ctrl_word[`UCRD_CTRL_ON_BIT] = port_switched_on_q;
        ctrl_word[`UCRD_CTRL_DMA_RECEIVE_REQUEST_ON_BIT] = dma_receive_request_on_q;
        ctrl_word[`UCRD_CTRL_CARD_BIT] = card_mode_q;
        ctrl_word[`UCRD_CTRL_HALT_BIT] = dma_halt_on_rx_error_q;
        ctrl_word[`UCRD_CTRL_DEM_BIT] = transceiver_control_on_q;
        ctrl_word[`UCRD_CTRL_DEP_BIT] = drive_output_polarity_q;
        ctrl_word[`UCRD_CTRL_RETRY_MSB:`UCRD_CTRL_RETRY_LSB] = card_retry_limit_q;
    end

    assign ctrl_new = ucrd_merge(ctrl_word, avs_writedata_in, avs_byteenable_in);
    assign limit_new = ctrl_new[`UCRD_CTRL_RETRY_MSB:`UCRD_CTRL_RETRY_LSB];
    assign retry_zero_wr = wr_ctrl & port_switched_on_q & (limit_new == 3'h0); // [R1]

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_switched_on_q <= 1'h0;
            dma_receive_request_on_q <= 1'h0;
            card_mode_q <= 1'h0;
            dma_halt_on_rx_error_q <= 1'h0;
            transceiver_control_on_q <= 1'h0;
            drive_output_polarity_q <= 1'h0;
        end else if (wr_ctrl) begin
            port_switched_on_q <= ctrl_new[`UCRD_CTRL_ON_BIT];
            dma_receive_request_on_q <= ctrl_new[`UCRD_CTRL_DMA_RECEIVE_REQUEST_ON_BIT];
            if (!port_switched_on_q) begin // [R7]
                card_mode_q <= CARD_SUPPORT & ctrl_new[`UCRD_CTRL_CARD_BIT];
                dma_halt_on_rx_error_q <= ctrl_new[`UCRD_CTRL_HALT_BIT];
                transceiver_control_on_q <= DRIVER_SUPPORT & ctrl_new[`UCRD_CTRL_DEM_BIT]; // [R8]
                drive_output_polarity_q <= DRIVER_SUPPORT & ctrl_new[`UCRD_CTRL_DEP_BIT]; // [R8]
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            card_retry_limit_q <= `UCRD_RETRY_RESET;
        end else if (!CARD_SUPPORT) begin
            card_retry_limit_q <= 3'h0; // [R4]
        end else if (wr_ctrl && !port_switched_on_q) begin
            card_retry_limit_q <= limit_new;
        end else if (retry_zero_wr) begin
            card_retry_limit_q <= 3'h0; // [R1]
        end
    end

    // ----------------------------------------
    // Retry counters
    // ----------------------------------------
    logic tx_retry_now;
    logic tx_exhaust;
    logic [2:0] tx_count;
    logic tx_active;
    logic rx_retry_now;
    logic rx_exhaust;
    logic [2:0] rx_count;
    logic rx_active;
    logic retry_stop;
    logic rx_take;
    logic rx_any_err;

    assign retry_stop = retry_zero_wr | ~port_switched_on_q; // [R1]
    assign rx_take = rx_char_valid_in & port_switched_on_q;
    assign rx_any_err = rx_parity_err_in | rx_frame_err_in | rx_noise_err_in;

    ucrd_retry_ctr u_tx_retry (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .limit_in(card_retry_limit_q),
        .fail_in(tx_nack_in & card_mode_q & port_switched_on_q),
        .success_in(tx_char_done_in),
        .stop_in(retry_stop),
        .retry_now_out(tx_retry_now),
        .exhaust_now_out(tx_exhaust),
        .count_out(tx_count),
        .active_out(tx_active)
    );

    ucrd_retry_ctr u_rx_retry (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .limit_in(card_retry_limit_q),
        .fail_in(rx_take & card_mode_q & rx_parity_err_in),
        .success_in(rx_take & ~rx_parity_err_in),
        .stop_in(retry_stop),
        .retry_now_out(rx_retry_now),
        .exhaust_now_out(rx_exhaust),
        .count_out(rx_count),
        .active_out(rx_active)
    );

    // ----------------------------------------
    // Receive events
    // ----------------------------------------
    logic rx_good;
    logic rx_err_evt;
    logic rdy_set;
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic [3:0] flags_q;
    logic [3:0] mask_q;
    logic [8:0] rx_data_q;
    logic err_pending;
    logic [31:0] mask_new;

    assign mask_new = ucrd_merge({28'h0, mask_q}, avs_writedata_in, avs_byteenable_in);

    assign rx_good = rx_take & ~rx_any_err;
    assign rx_err_evt = rx_take & rx_any_err & ~rx_retry_now; // [R12]
    assign rdy_set = rx_good | (rx_err_evt & dma_halt_on_rx_error_q); // [R9] [R10]

    always_comb begin
        flag_set = 4'h0;
        flag_set[`UCRD_FLAG_RDY_BIT] = rdy_set;
        flag_set[`UCRD_FLAG_PE_BIT] = rx_err_evt & rx_parity_err_in; // [R12]
        flag_set[`UCRD_FLAG_FE_BIT] = (rx_err_evt & rx_frame_err_in) | tx_exhaust; // [R12]
        flag_set[`UCRD_FLAG_NF_BIT] = rx_err_evt & rx_noise_err_in;
        flag_clr = wr_status ? (avs_writedata_in[3:0] & {4{avs_byteenable_in[0]}}) : 4'h0;
        flag_clr[`UCRD_FLAG_RDY_BIT] = flag_clr[`UCRD_FLAG_RDY_BIT] | rd_data | dma_rx_ack_in;
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_data_q <= `UCRD_DATA_RESET;
        end else if (rdy_set) begin
            rx_data_q <= rx_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_q <= `UCRD_MASK_RESET;
        end else if (wr_mask) begin
            mask_q <= mask_new[3:0];
        end
    end

    // With DMA halt on, error flags still set hold the DMA request off; software clears ready first
    assign err_pending = flags_q[`UCRD_FLAG_PE_BIT] | flags_q[`UCRD_FLAG_FE_BIT]
                       | flags_q[`UCRD_FLAG_NF_BIT];
    assign dma_rx_req_out = dma_receive_request_on_q & flags_q[`UCRD_FLAG_RDY_BIT]
                          & ~(dma_halt_on_rx_error_q & err_pending); // [R10] [R11]
    assign irq_out = |(flags_q & mask_q);

    // ----------------------------------------
    // Line side outputs
    // ----------------------------------------
    logic rts_pin_q;
    logic tx_retransmit_q;
    logic tx_retry_stop_q;
    logic rx_nack_q;
    logic drive_active;

    assign drive_active = port_switched_on_q & tx_busy_in;

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rts_pin_q <= 1'h0;
        end else if (transceiver_control_on_q) begin
            rts_pin_q <= drive_active ^ drive_output_polarity_q; // [R5] [R6]
        end else begin
            rts_pin_q <= rts_flow_in;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_retransmit_q <= 1'h0;
            tx_retry_stop_q <= 1'h0;
            rx_nack_q <= 1'h0;
        end else begin
            tx_retransmit_q <= tx_retry_now; // [R3]
            tx_retry_stop_q <= retry_zero_wr; // [R1]
            rx_nack_q <= rx_retry_now; // [R12]
        end
    end

    assign rts_pin_out = rts_pin_q;
    assign tx_retransmit_out = tx_retransmit_q;
    assign tx_retry_stop_out = tx_retry_stop_q;
    assign rx_nack_out = rx_nack_q;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rd_word = `UCRD_WORD_RESET;
        case (avs_address_in)
            `UCRD_OFF_CTRL: rd_word = ctrl_word;
            `UCRD_OFF_STATUS: rd_word[3:0] = flags_q;
            `UCRD_OFF_MASK: rd_word[3:0] = mask_q;
            `UCRD_OFF_DATA: rd_word[8:0] = rx_data_q;
            `UCRD_OFF_STATE: begin
                rd_word[`UCRD_STATE_RX_LSB+:3] = rx_count;
                rd_word[`UCRD_STATE_TX_LSB+:3] = tx_count;
                rd_word[`UCRD_STATE_TX_ACT_BIT] = tx_active;
                rd_word[`UCRD_STATE_RX_ACT_BIT] = rx_active;
            end
            default: rd_word = `UCRD_WORD_RESET;
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            readdata_q <= `UCRD_WORD_RESET;
        end else if (avs_read_in && !ack_q) begin
            readdata_q <= rd_word;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_zero_write_only: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R1]
        (wr_ctrl && port_switched_on_q && limit_new != 3'h0)
        |=> $stable(card_retry_limit_q))
        else $error("nonzero retry limit taken while on");

    a_stop_clears: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R1]
        retry_zero_wr |=> tx_count == 3'h0 && tx_retry_stop_out ##1 !tx_retry_stop_out)
        else $error("zero write did not stop retries");

    a_no_retry_zero: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R2]
        tx_retransmit_out |-> $past(card_retry_limit_q) != 3'h0)
        else $error("retransmit with zero limit");

    a_hw_zero: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R4]
        !CARD_SUPPORT |-> ##1 card_retry_limit_q == 3'h0)
        else $error("retry limit not held at zero");

    a_drive_level: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R5]
        $past(transceiver_control_on_q)
        |-> rts_pin_out == ($past(drive_active) ^ $past(drive_output_polarity_q)))
        else $error("drive output level wrong");

    a_rts_pass: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R6]
        !transceiver_control_on_q |=> rts_pin_out == $past(rts_flow_in))
        else $error("flow level not passed when drive off");

    a_cfg_hold: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R7]
        $past(port_switched_on_q) |-> $stable(transceiver_control_on_q)
        && $stable(drive_output_polarity_q) && $stable(dma_halt_on_rx_error_q))
        else $error("config changed while port on");

    a_drv_absent: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R8]
        !DRIVER_SUPPORT |-> !transceiver_control_on_q && !drive_output_polarity_q)
        else $error("driver bits set without support");

    a_err_no_ready: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R9]
        (rx_err_evt && !dma_halt_on_rx_error_q && !flags_q[`UCRD_FLAG_RDY_BIT])
        |=> !flags_q[`UCRD_FLAG_RDY_BIT] && err_pending)
        else $error("ready raised on bad character");

    a_dma_mask: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R10]
        (rx_err_evt && dma_halt_on_rx_error_q)
        |=> flags_q[`UCRD_FLAG_RDY_BIT] && !dma_rx_req_out)
        else $error("dma request not masked after error");

    a_tx_exhaust_fe: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R12]
        tx_exhaust |=> flags_q[`UCRD_FLAG_FE_BIT] && !tx_retransmit_out)
        else $error("frame error missing after last retry");

endmodule // ucrd_ctrl

//--- design/ucrd_map.svh
// Register offsets, field positions and reset values of the card retry control block
`ifndef UCRD_MAP_SVH
`define UCRD_MAP_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define UCRD_ADDR_W 5
`define UCRD_DATA_W 32

// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define UCRD_OFF_CTRL 5'h00
`define UCRD_OFF_STATUS 5'h04
`define UCRD_OFF_MASK 5'h08
`define UCRD_OFF_DATA 5'h0C
`define UCRD_OFF_STATE 5'h10

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define UCRD_CTRL_ON_BIT 0
`define UCRD_CTRL_DMA_RECEIVE_REQUEST_ON_BIT 1
`define UCRD_CTRL_CARD_BIT 2
`define UCRD_CTRL_HALT_BIT 13
`define UCRD_CTRL_DEM_BIT 14
`define UCRD_CTRL_DEP_BIT 15
`define UCRD_CTRL_RETRY_LSB 17
`define UCRD_CTRL_RETRY_MSB 19

// ----------------------------------------
// Status and mask fields
// ----------------------------------------
`define UCRD_FLAG_W 4
`define UCRD_FLAG_RDY_BIT 0
`define UCRD_FLAG_PE_BIT 1
`define UCRD_FLAG_FE_BIT 2
`define UCRD_FLAG_NF_BIT 3

// ----------------------------------------
// Retry state word fields
// ----------------------------------------
`define UCRD_STATE_RX_LSB 0
`define UCRD_STATE_TX_LSB 4
`define UCRD_STATE_TX_ACT_BIT 8
`define UCRD_STATE_RX_ACT_BIT 9

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UCRD_RETRY_RESET 3'h0
`define UCRD_MASK_RESET 4'h0
`define UCRD_DATA_RESET 9'h000
`define UCRD_WORD_RESET 32'h0000_0000

`endif

//--- design/ucrd_pkg.sv
// Types shared by the card retry control block
package ucrd_pkg;

    // ----------------------------------------
    // Retry counter states
    // ----------------------------------------
    typedef enum logic [1:0] {
        UCRD_ST_IDLE = 2'h1,
        UCRD_ST_RETRY = 2'h2
    } ucrd_retry_state_t;

    typedef logic [2:0] ucrd_count_t;

endpackage

//--- design/ucrd_retry_ctr.sv
// Retry attempt counter shared by the transmit and receive paths
module ucrd_retry_ctr (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic [2:0] limit_in,
    input wire logic fail_in,
    input wire logic success_in,
    input wire logic stop_in,
    output logic retry_now_out,
    output logic exhaust_now_out,
    output logic [2:0] count_out,
    output logic active_out
);

    ucrd_pkg::ucrd_retry_state_t state_q;
    ucrd_pkg::ucrd_retry_state_t state_d;
    ucrd_pkg::ucrd_count_t count_q;
    ucrd_pkg::ucrd_count_t count_d;

    // ----------------------------------------
    // Attempt decision
    // ----------------------------------------
    always_comb begin
        retry_now_out = 1'h0;
        exhaust_now_out = 1'h0;
        count_d = count_q;
        state_d = state_q;
        case (state_q)
            ucrd_pkg::UCRD_ST_IDLE, ucrd_pkg::UCRD_ST_RETRY: begin
                if (stop_in) begin
                    count_d = 3'h0;
                    state_d = ucrd_pkg::UCRD_ST_IDLE;
                end else if (fail_in) begin
                    if (count_q < limit_in) begin // [R2] [R3]
                        retry_now_out = 1'h1;
                        count_d = count_q + 3'h1;
                        state_d = ucrd_pkg::UCRD_ST_RETRY;
                    end else begin
                        exhaust_now_out = 1'h1; // [R3]
                        count_d = 3'h0;
                        state_d = ucrd_pkg::UCRD_ST_IDLE;
                    end
                end else if (success_in) begin
                    count_d = 3'h0;
                    state_d = ucrd_pkg::UCRD_ST_IDLE;
                end
            end
            default: begin
                count_d = 3'h0;
                state_d = ucrd_pkg::UCRD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= ucrd_pkg::UCRD_ST_IDLE;
            count_q <= 3'h0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign count_out = count_q;
    assign active_out = (state_q == ucrd_pkg::UCRD_ST_RETRY);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_count_bound: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R3]
        count_q <= limit_in)
        else $error("retry count above limit");

    a_zero_no_retry: assert property (@(posedge clock_in) disable iff (!resetn_in) // [R2]
        (fail_in && !stop_in && limit_in == 3'h0) |-> !retry_now_out && exhaust_now_out)
        else $error("retry with zero limit");

endmodule // ucrd_retry_ctr

//--- verif/ucrd_card_model.sv
// Card side model: answers sent characters with a set number of error signals
module ucrd_card_model (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic send_in,
    input wire logic tx_retransmit_in,
    input wire logic [2:0] nack_count_in,
    output logic tx_busy_out,
    output logic tx_nack_out,
    output logic tx_char_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] nacks_q;
    logic [1:0] wait_q;
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            nacks_q <= 3'h0;
            wait_q <= 2'h0;
            tx_busy_out <= 1'b0;
            tx_nack_out <= 1'b0;
            tx_char_done_out <= 1'b0;
        end else begin
            tx_nack_out <= 1'b0;
            tx_char_done_out <= 1'b0;
            if (send_in || tx_retransmit_in) begin
                wait_q <= 2'h3;
                tx_busy_out <= 1'b1;
                if (send_in) nacks_q <= 3'h0;
            end else if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
                if (wait_q == 2'h1) begin
                    tx_busy_out <= 1'b0;
                    if (nacks_q < nack_count_in) begin
                        tx_nack_out <= 1'b1;
                        nacks_q <= nacks_q + 3'h1;
                    end else begin
                        tx_char_done_out <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // ucrd_card_model

//--- verif/ucrd_ctrl_tb_top.sv
// Self-checking bench of the card retry control block
module ucrd_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ON = 32'h1, DMA_RECEIVE_REQUEST_ON = 32'h2, CARD = 32'h4, HALT = 32'h2000;
    localparam logic [31:0] TRANSCEIVER_CONTROL_ON = 32'h4000, DRIVE_OUTPUT_POLARITY = 32'h8000, L2 = 32'h40000, L5 = 32'hA0000;
    logic clk = 1'b0, rst_n = 1'b0, rd_s = 1'b0, wr_s = 1'b0, rflow = 1'b0, rv = 1'b0;
    logic pe = 1'b0, fe = 1'b0, dack = 1'b0, send = 1'b0;
    logic [4:0] a = 5'h00;
    logic [31:0] wd = 32'h0, rdat, rdat2, q;
    logic [8:0] rdd = 9'h000;
    logic [2:0] ncnt = 3'h0;
    logic wreq, busy, nack, done, rtx, stop, rts, dreq, irq, rnack;
    int fail_count = 0, tests_run = 0, rtx_n = 0, stop_n = 0, rnack_n = 0, base;
    ucrd_ctrl uut (.clock_in(clk), .resetn_in(rst_n), .avs_address_in(a), .avs_read_in(rd_s),
        .avs_write_in(wr_s), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .tx_busy_in(busy),
        .tx_nack_in(nack), .tx_char_done_in(done), .rts_flow_in(rflow),
        .rx_char_valid_in(rv), .rx_data_in(rdd), .rx_parity_err_in(pe),
        .rx_frame_err_in(fe), .rx_noise_err_in(1'b0), .dma_rx_ack_in(dack),
        .tx_retransmit_out(rtx), .tx_retry_stop_out(stop), .rx_nack_out(rnack),
        .rts_pin_out(rts), .dma_rx_req_out(dreq), .irq_out(irq));
    ucrd_ctrl #(.CARD_SUPPORT(1'h0), .DRIVER_SUPPORT(1'h0)) uut_min (.clock_in(clk),
        .resetn_in(rst_n), .avs_address_in(a), .avs_read_in(rd_s), .avs_write_in(wr_s),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat2),
        .avs_waitrequest_out(), .tx_busy_in(busy), .tx_nack_in(nack), .tx_char_done_in(done),
        .rts_flow_in(rflow), .rx_char_valid_in(rv), .rx_data_in(rdd), .rx_parity_err_in(pe),
        .rx_frame_err_in(fe), .rx_noise_err_in(1'h0), .dma_rx_ack_in(dack),
        .tx_retransmit_out(), .tx_retry_stop_out(), .rx_nack_out(), .rts_pin_out(),
        .dma_rx_req_out(), .irq_out());
    ucrd_card_model card (.clock_in(clk), .resetn_in(rst_n), .send_in(send),
        .tx_retransmit_in(rtx), .nack_count_in(ncnt), .tx_busy_out(busy),
        .tx_nack_out(nack), .tx_char_done_out(done));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rtx === 1'b1) rtx_n++;
        if (stop === 1'b1) stop_n++;
        if (rnack === 1'b1) rnack_n++;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        a <= ad;
        wd <= d;
        wr_s <= w;
        rd_s <= !w;
        do begin
            @(negedge clk);
            n++;
        end while (wreq !== 1'b0);
        @(posedge clk);
        q = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        chk("wait_cycles", 32'h2, n);
    endtask
    task automatic rc(input logic [4:0] ad, input logic [31:0] e, input string nm);
        bus(1'b0, ad, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic rx(input logic [8:0] d, input logic [1:0] e);
        @(posedge clk);
        rv <= 1'b1;
        rdd <= d;
        fe <= e[0];
        pe <= e[1];
        @(posedge clk);
        rv <= 1'b0;
        fe <= 1'b0;
        pe <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic pulse_ack();
        @(posedge clk);
        dack <= 1'b1;
        @(posedge clk);
        dack <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic tx(input logic [2:0] n, input logic e_rts);
        base = rtx_n;
        @(posedge clk);
        ncnt <= n;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        #1;
        chk("rts_pin", {31'h0, e_rts}, {31'h0, rts});
        repeat (60) @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        wrap_up();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rc(5'h00, 32'h0, "ctrl");
        rc(5'h10, 32'h0, "state");
        rc(5'h14, 32'h0, "unmapped");
        bus(1'b1, 5'h00, CARD | TRANSCEIVER_CONTROL_ON | L2);
        bus(1'b1, 5'h00, ON | CARD | TRANSCEIVER_CONTROL_ON | L2);
        bus(1'b1, 5'h08, 32'h4);
        tx(3'h5, 1'b1);
        chk("retransmits", 32'd2, rtx_n - base);
        rc(5'h04, 32'h4, "status");
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, 5'h08, 32'h0);
        #1;
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, 5'h04, 32'h4);
        repeat (3) rx(9'h011, 2'h2);
        chk("rx_nacks", 32'h2, rnack_n);
        rc(5'h04, 32'h2, "status");
        bus(1'b1, 5'h04, 32'h2);
        bus(1'b1, 5'h00, ON | CARD | TRANSCEIVER_CONTROL_ON | DRIVE_OUTPUT_POLARITY | HALT | L5);
        rc(5'h00, ON | CARD | TRANSCEIVER_CONTROL_ON | L2, "ctrl");
        chk("ctrl_min", ON, rdat2);
        bus(1'b1, 5'h00, ON | CARD | TRANSCEIVER_CONTROL_ON);
        rc(5'h00, ON | CARD | TRANSCEIVER_CONTROL_ON, "ctrl");
        chk("stop", 32'd1, stop_n);
        tx(3'h1, 1'b1);
        chk("retransmits", 32'd0, rtx_n - base);
        rc(5'h04, 32'h4, "status");
        bus(1'b1, 5'h04, 32'h4);
        bus(1'b1, 5'h00, ON | DMA_RECEIVE_REQUEST_ON | CARD | TRANSCEIVER_CONTROL_ON);
        rx(9'h0A5, 2'h0);
        chk("dma_req", 32'h1, {31'h0, dreq});
        rc(5'h0C, 32'h0A5, "data");
        rx(9'h03C, 2'h1);
        rc(5'h04, 32'h4, "status");
        chk("dma_req", 32'h0, {31'h0, dreq});
        rx(9'h1C3, 2'h0);
        chk("dma_req", 32'h1, {31'h0, dreq});
        pulse_ack();
        bus(1'b1, 5'h04, 32'h4);
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b1, 5'h00, HALT | DMA_RECEIVE_REQUEST_ON | TRANSCEIVER_CONTROL_ON | DRIVE_OUTPUT_POLARITY);
        bus(1'b1, 5'h00, ON | HALT | DMA_RECEIVE_REQUEST_ON | TRANSCEIVER_CONTROL_ON | DRIVE_OUTPUT_POLARITY);
        #1;
        chk("rts_pin", 32'h1, {31'h0, rts});
        rx(9'h055, 2'h1);
        rc(5'h04, 32'h5, "status");
        chk("dma_req", 32'h0, {31'h0, dreq});
        pulse_ack();
        bus(1'b1, 5'h04, 32'h4);
        rx(9'h0AA, 2'h0);
        chk("dma_req", 32'h1, {31'h0, dreq});
        tx(3'h0, 1'b0);
        bus(1'b1, 5'h00, 32'h0);
        bus(1'b1, 5'h00, ON);
        rflow <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("rts_pin", 32'h1, {31'h0, rts});
        wrap_up();
    end
endmodule // ucrd_ctrl_tb_top
